// >>> periph_enable_pkg.sv
package periph_enable_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_OFFSET = 16'hF024;
    localparam int CFG_WIDTH = 5;
    localparam logic [4:0] CFG_RESET = 5'h05;
    localparam logic [4:0] CFG_ALL_ENABLED = 5'h1F;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;

    // ----------------------------------------------------------------
    // Field positions of the enable register
    // ----------------------------------------------------------------
    localparam int FIRST_CAN_ENABLE = 0;
    localparam int SECOND_CAN_ENABLE = 1;
    localparam int SMALL_XRAM_ENABLE = 2;
    localparam int LARGE_XRAM_ENABLE = 3;
    localparam int RTC_BLOCK_ENABLE = 4;

    // ----------------------------------------------------------------
    // Address windows, inclusive bounds
    // ----------------------------------------------------------------
    localparam logic [23:0] CAN1_LO = 24'h00EF00;
    localparam logic [23:0] CAN1_HI = 24'h00EFFF;
    localparam logic [23:0] CAN2_LO = 24'h00EE00;
    localparam logic [23:0] CAN2_HI = 24'h00EEFF;
    localparam logic [23:0] RTC_LO = 24'h00EC00;
    localparam logic [23:0] RTC_HI = 24'h00ECFF;
    localparam logic [23:0] XRAM1_LO = 24'h00E000;
    localparam logic [23:0] XRAM1_HI = 24'h00E7FF;
    localparam logic [23:0] XRAM2_LO = 24'h00C000;
    localparam logic [23:0] XRAM2_HI = 24'h00DFFF;

endpackage

// >>> decode_if.sv
`timescale 1ns/1ps
// Carries one access address and the effective enables to the window
// decoder, and the routing verdict back.
interface decode_if;
    logic [23:0] addr;
    logic [4:0] en;
    logic to_can1;
    logic to_can2;
    logic to_rtc;
    logic to_xram1;
    logic to_xram2;
    logic to_external;
    logic blocked;
    logic in_can_window;

    modport decoder (
        input addr,
        input en,
        output to_can1,
        output to_can2,
        output to_rtc,
        output to_xram1,
        output to_xram2,
        output to_external,
        output blocked,
        output in_can_window
    );

    modport user (
        output addr,
        output en,
        input to_can1,
        input to_can2,
        input to_rtc,
        input to_xram1,
        input to_xram2,
        input to_external,
        input blocked,
        input in_can_window
    );
endinterface // decode_if

// >>> window_decoder.sv
`timescale 1ns/1ps
module window_decoder (
    decode_if.decoder dif
);

    // ----------------------------------------------------------------
    // Window hits
    // ----------------------------------------------------------------
    logic hit_can1;
    logic hit_can2;
    logic hit_rtc;
    logic hit_x1;
    logic hit_x2;
    logic any_can;

    // Range compares on the full address so higher segments never alias.
    assign hit_can1 = (dif.addr >= periph_enable_pkg::CAN1_LO) &&
                      (dif.addr <= periph_enable_pkg::CAN1_HI);
    assign hit_can2 = (dif.addr >= periph_enable_pkg::CAN2_LO) &&
                      (dif.addr <= periph_enable_pkg::CAN2_HI);
    assign hit_rtc = (dif.addr >= periph_enable_pkg::RTC_LO) &&
                     (dif.addr <= periph_enable_pkg::RTC_HI);
    assign hit_x1 = (dif.addr >= periph_enable_pkg::XRAM1_LO) &&
                    (dif.addr <= periph_enable_pkg::XRAM1_HI);
    assign hit_x2 = (dif.addr >= periph_enable_pkg::XRAM2_LO) &&
                    (dif.addr <= periph_enable_pkg::XRAM2_HI);
    assign any_can = dif.en[periph_enable_pkg::FIRST_CAN_ENABLE] |
                     dif.en[periph_enable_pkg::SECOND_CAN_ENABLE];

    // ----------------------------------------------------------------
    // Routing verdict
    // ----------------------------------------------------------------
    // A disabled CAN or clock window stays blocked while either CAN is on,
    // because the CAN block still owns the whole combined area then.
    always_comb begin
        dif.to_can1 = hit_can1 & dif.en[periph_enable_pkg::FIRST_CAN_ENABLE];
        dif.to_can2 = hit_can2 & dif.en[periph_enable_pkg::SECOND_CAN_ENABLE];
        dif.to_rtc = hit_rtc & dif.en[periph_enable_pkg::RTC_BLOCK_ENABLE];
        dif.to_xram1 = hit_x1 & dif.en[periph_enable_pkg::SMALL_XRAM_ENABLE];
        dif.to_xram2 = hit_x2 & dif.en[periph_enable_pkg::LARGE_XRAM_ENABLE];
        dif.blocked = ((hit_can1 | hit_can2 | hit_rtc) & any_can) &
                      ~(dif.to_can1 | dif.to_can2 | dif.to_rtc);
        dif.to_external = ~(dif.to_can1 | dif.to_can2 | dif.to_rtc |
                            dif.to_xram1 | dif.to_xram2 | dif.blocked);
        dif.in_can_window = hit_can1 | hit_can2;
    end

endmodule // window_decoder

// >>> onchip_peripheral_enable_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Reset value 05h: CAN1, small RAM on.
// - CAN1 off: blocked, its port pins freed.
// - CAN2 off: blocked, its port pins freed.
// - CAN1 window external only if both off.
// - CAN2 window external only if both off.
// - Small RAM window: internal if enabled, else external.
// - Large RAM window: internal if enabled, else external.
// - Clock off: blocked; external only if CANs off.
// - Both CANs off: CAN area goes external.
// - Global enable set locks register against writes.
// - Mode_a mode forces every enable bit set.
// - Clock enable and oscillator-off select decide oscillator stop at power-down.
module onchip_peripheral_enable_decoder #(
    parameter int ADDR_WIDTH = 24
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic global_xperiph_enable,
    input wire logic mode_a,
    input wire logic powerdown_req,
    input wire logic oscillator_off_select,
    input wire logic acc_valid,
    input wire logic [ADDR_WIDTH-1:0] acc_addr,
    output logic route_valid,
    output logic route_can1,
    output logic route_can2,
    output logic route_rtc,
    output logic route_xram1,
    output logic route_xram2,
    output logic route_external,
    output logic route_blocked,
    output logic can1_pins_gpio,
    output logic can2_pins_gpio,
    output logic rtc_osc_stop
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // The windows are compared as 24-bit addresses.
    generate
        if (ADDR_WIDTH != 24) begin : g_bad_width
            $error("ADDR_WIDTH must be 24");
        end
    endgenerate

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] cfg;
        logic locked;
        logic mode_meta;
        logic mode_sync;
        logic [15:0] rdata;
        logic valid;
        logic can1;
        logic can2;
        logic rtc;
        logic xram1;
        logic xram2;
        logic external;
        logic blocked;
        logic gpio1;
        logic gpio2;
        logic osc_stop;
    } state_s;

    state_s st;
    state_s next_st;

    logic [4:0] eff_en;
    logic cfg_hit;
    logic lock_now;

    decode_if dif ();

    // ----------------------------------------------------------------
    // Window decoder
    // ----------------------------------------------------------------
    window_decoder u_dec (
        .dif(dif.decoder)
    );

    // Decoder sees the effective enables, so mode_a reroutes once synchronised.
    assign dif.addr = acc_addr;
    assign dif.en = eff_en;

    // ----------------------------------------------------------------
    // Derived terms
    // ----------------------------------------------------------------
    // Mode_a only ever adds enables; the stored bits stay untouched so
    // leaving mode_a restores the programmed map.
    assign eff_en = st.mode_sync ? periph_enable_pkg::CFG_ALL_ENABLED : st.cfg;
    assign cfg_hit = (reg_addr == periph_enable_pkg::CFG_OFFSET);
    // The lock takes effect in the same cycle the global enable rises.
    assign lock_now = st.locked | global_xperiph_enable;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // The mode_a strap comes from a pin and is synchronised first.
        next_st.mode_meta = mode_a;
        next_st.mode_sync = st.mode_meta;

        // Once locked, the register never opens again until reset.
        next_st.locked = lock_now;

        // Only the five enable bits are stored; the rest is dropped.
        if (reg_wr && cfg_hit && !lock_now) begin
            next_st.cfg = reg_wdata[periph_enable_pkg::CFG_WIDTH-1:0];
        end

        // Read data stand for one cycle only; unmapped reads return zero.
        next_st.rdata = periph_enable_pkg::RDATA_IDLE;
        if (reg_rd && cfg_hit) begin
            next_st.rdata = {11'h000, eff_en};
        end

        // Routing verdict for the access presented this cycle.
        next_st.valid = acc_valid;
        next_st.can1 = acc_valid & dif.to_can1;
        next_st.can2 = acc_valid & dif.to_can2;
        next_st.rtc = acc_valid & dif.to_rtc;
        next_st.xram1 = acc_valid & dif.to_xram1;
        next_st.xram2 = acc_valid & dif.to_xram2;
        next_st.external = acc_valid & dif.to_external;
        next_st.blocked = acc_valid & dif.blocked;

        // A disabled CAN hands its two port pins to general I/O.
        next_st.gpio1 = ~eff_en[periph_enable_pkg::FIRST_CAN_ENABLE];
        next_st.gpio2 = ~eff_en[periph_enable_pkg::SECOND_CAN_ENABLE];

        // Without the clock block the oscillator always stops in power-down.
        next_st.osc_stop = powerdown_req &
                           (~eff_en[periph_enable_pkg::RTC_BLOCK_ENABLE] |
                            oscillator_off_select);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '0;
            st.cfg <= periph_enable_pkg::CFG_RESET;
            st.gpio2 <= 1'b1;
            st.osc_stop <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output is a plain copy of a state bit.
    assign reg_rdata = st.rdata;
    assign route_valid = st.valid;
    assign route_can1 = st.can1;
    assign route_can2 = st.can2;
    assign route_rtc = st.rtc;
    assign route_xram1 = st.xram1;
    assign route_xram2 = st.xram2;
    assign route_external = st.external;
    assign route_blocked = st.blocked;
    assign can1_pins_gpio = st.gpio1;
    assign can2_pins_gpio = st.gpio2;
    assign rtc_osc_stop = st.osc_stop;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // The register holds 05h in the first cycle after reset release.
    property p_reset_value;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (st.cfg == 5'h05);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("enable register not 05h after reset");

    // With the first CAN disabled its window never reaches it.
    property p_can1_blocked;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && !eff_en[0] && acc_addr[23:8] == 16'h00EF) |=>
            (!route_can1 && (route_blocked || route_external));
    endproperty
    a_can1_blocked: assert property (p_can1_blocked)
        else $error("first CAN reached while disabled");

    // Port pins follow the CAN enables one cycle later.
    property p_pins_free;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (can1_pins_gpio == !$past(eff_en[0])) &&
                 (can2_pins_gpio == !$past(eff_en[1]));
    endproperty
    a_pins_free: assert property (p_pins_free)
        else $error("CAN pin release wrong");

    // A CAN window goes outside only when both CANs are disabled.
    property p_can_external;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && (acc_addr[23:8] == 16'h00EE || acc_addr[23:8] == 16'h00EF)) |=>
            (route_external == ($past(eff_en[1:0]) == 2'b00));
    endproperty
    a_can_external: assert property (p_can_external)
        else $error("CAN area routed wrongly");

    // Second CAN window with only the first CAN on is blocked.
    property p_can2_blocked;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && eff_en[1:0] == 2'b01 && acc_addr[23:8] == 16'h00EE) |=>
            (route_blocked && !route_can2);
    endproperty
    a_can2_blocked: assert property (p_can2_blocked)
        else $error("second CAN window not blocked");

    // First CAN window with only the second CAN on is blocked.
    property p_can1_held;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && eff_en[1:0] == 2'b10 && acc_addr[23:8] == 16'h00EF) |=>
            route_blocked;
    endproperty
    a_can1_held: assert property (p_can1_held)
        else $error("first CAN window not blocked");

    // Small RAM window follows its enable bit.
    property p_xram1;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && acc_addr >= 24'h00E000 && acc_addr <= 24'h00E7FF) |=>
            (route_xram1 == $past(eff_en[2])) && (route_external == !$past(eff_en[2]));
    endproperty
    a_xram1: assert property (p_xram1)
        else $error("small RAM window misrouted");

    // Large RAM window follows its enable bit.
    property p_xram2;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && acc_addr >= 24'h00C000 && acc_addr <= 24'h00DFFF) |=>
            (route_xram2 == $past(eff_en[3])) && (route_external == !$past(eff_en[3]));
    endproperty
    a_xram2: assert property (p_xram2)
        else $error("large RAM window misrouted");

    // Clock window when disabled: never internal, blocked while a CAN is on.
    property p_rtc;
        @(posedge clk) disable iff (!nrst)
        (acc_valid && acc_addr[23:8] == 16'h00EC && !eff_en[4]) |=>
            (!route_rtc && (route_blocked == ($past(eff_en[1:0]) != 2'b00)));
    endproperty
    a_rtc: assert property (p_rtc)
        else $error("clock window misrouted");

    // A locked register ignores writes.
    property p_locked;
        @(posedge clk) disable iff (!nrst)
        (lock_now && reg_wr) |=> $stable(st.cfg) && st.locked;
    endproperty
    a_locked: assert property (p_locked)
        else $error("write changed locked register");

    // Mode_a reads back all enables two cycles after the strap rises.
    property p_mode_a;
        @(posedge clk) disable iff (!nrst)
        (mode_a ##1 mode_a ##1 (reg_rd && cfg_hit)) |=> (reg_rdata == 16'h001F);
    endproperty
    a_mode_a: assert property (p_mode_a)
        else $error("mode_a did not force enables");

    // Oscillator stop follows power-down and the clock enable.
    property p_osc;
        @(posedge clk) disable iff (!nrst)
        (powerdown_req && !eff_en[4]) |=> rtc_osc_stop;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator not stopped in power-down");

    // An open write stores the low five bits and upper bits read zero.
    property p_write_read;
        @(posedge clk) disable iff (!nrst)
        (reg_wr && cfg_hit && !lock_now && !st.mode_sync && !mode_a)
            ##1 (reg_rd && cfg_hit && !st.mode_sync) |=>
            (reg_rdata == {11'h000, $past(reg_wdata[4:0], 2)});
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("write then read mismatch");

    // Read data stand only in the cycle after a mapped read.
    property p_rdata_idle;
        @(posedge clk) disable iff (!nrst)
        !(reg_rd && cfg_hit) |=> (reg_rdata == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data shown outside a read");

    // Every access gets exactly one verdict in the following cycle.
    property p_one_verdict;
        @(posedge clk) disable iff (!nrst)
        acc_valid |=> route_valid && $onehot({route_can1, route_can2, route_rtc,
            route_xram1, route_xram2, route_external, route_blocked});
    endproperty
    a_one_verdict: assert property (p_one_verdict)
        else $error("access verdict not one-hot");

    // No valid, external or blocked verdict is shown without an access one cycle earlier.
    property p_idle_quiet;
        @(posedge clk) disable iff (!nrst)
        !acc_valid |=> (!route_valid && !route_external && !route_blocked);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("verdict without an access");

    // The global enable sets the stored lock bit from the next cycle on.
    property p_lock_set;
        @(posedge clk) disable iff (!nrst)
        global_xperiph_enable |=> st.locked;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("global enable did not lock");

    // Pin release and oscillator stop start from the reset enables.
    property p_reset_pins;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (!can1_pins_gpio && can2_pins_gpio && !rtc_osc_stop);
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("pin levels wrong after reset");

    // Without a power-down request the oscillator never stops.
    property p_osc_run;
        @(posedge clk) disable iff (!nrst)
        !powerdown_req |=> !rtc_osc_stop;
    endproperty
    a_osc_run: assert property (p_osc_run)
        else $error("oscillator stopped outside power-down");

    // With the clock block on, the oscillator-off bit decides.
    property p_osc_select;
        @(posedge clk) disable iff (!nrst)
        (powerdown_req && eff_en[4]) |=> (rtc_osc_stop == $past(oscillator_off_select));
    endproperty
    a_osc_select: assert property (p_osc_select)
        else $error("oscillator-off choice ignored");

endmodule // onchip_peripheral_enable_decoder

// >>> access_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Internal bus master issuing accesses into the decoded windows
// ----------------------------------------------------------------
module access_master (
    input wire logic clk,
    output logic acc_valid,
    output logic [23:0] acc_addr
);
    // Idle at time zero so the decoder never samples an unknown request.
    initial begin
        acc_valid = 1'b0;
        acc_addr = 24'h000000;
    end

    // One access per call. A gap of zero keeps the request up for a
    // back-to-back access; otherwise the address turns to its inverse so a
    // stale address can never pass for a held one.
    task automatic send(input logic [23:0] a, input int gap);
        acc_valid <= 1'b1;
        acc_addr <= a;
        @(posedge clk);
        if (gap > 0) begin
            acc_valid <= 1'b0;
            acc_addr <= ~a;
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule // access_master

// >>> tb_onchip_peripheral_enable_decoder.sv
`timescale 1ns/1ps
module tb_onchip_peripheral_enable_decoder;
    logic clk;
    logic nrst;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic global_xperiph_enable;
    logic mode_a;
    logic powerdown_req;
    logic oscillator_off_select;
    logic acc_valid;
    logic [23:0] acc_addr;
    logic route_valid, route_can1, route_can2, route_rtc, route_xram1, route_xram2;
    logic route_external, route_blocked, can1_pins_gpio, can2_pins_gpio, rtc_osc_stop;
    logic [6:0] route_vec;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] rng = 32'h9A9C;
    logic [4:0] cfg;
    logic lock;
    logic emu;
    logic started = 1'b0;
    logic acc_d = 1'b0;
    logic rd_d = 1'b0;
    logic [6:0] aq[$];
    logic [15:0] rq[$];
    logic [23:0] addrs [14] = '{24'h00EF00, 24'h00EFFF, 24'h00EE00, 24'h00EEFF,
        24'h00EC00, 24'h00ECFF, 24'h00E000, 24'h00E7FF, 24'h00C000, 24'h00DFFF,
        24'h00EDFF, 24'h00E800, 24'h00BFFF, 24'h01EF00};

    // ----------------------------------------------------------------
    // Clock, partner and design
    // ----------------------------------------------------------------
    // Free-running 40 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    assign route_vec = {route_can1, route_can2, route_rtc, route_xram1, route_xram2,
        route_external, route_blocked};

    access_master i_access_master (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr));

    onchip_peripheral_enable_decoder i_onchip_peripheral_enable_decoder (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .global_xperiph_enable(global_xperiph_enable), .mode_a(mode_a),
        .powerdown_req(powerdown_req), .oscillator_off_select(oscillator_off_select),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .route_valid(route_valid),
        .route_can1(route_can1), .route_can2(route_can2), .route_rtc(route_rtc),
        .route_xram1(route_xram1), .route_xram2(route_xram2),
        .route_external(route_external), .route_blocked(route_blocked),
        .can1_pins_gpio(can1_pins_gpio), .can2_pins_gpio(can2_pins_gpio),
        .rtc_osc_stop(rtc_osc_stop));

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic logic [15:0] rand16();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction

    // Mode_a overrides the stored bits, which survive underneath.
    function automatic logic [4:0] eff();
        return emu ? 5'h1F : cfg;
    endfunction

    // Verdict order: can1, can2, rtc, xram1, xram2, external, blocked.
    function automatic logic [6:0] route_exp(input logic [23:0] a, input logic [4:0] e);
        if (a >= 24'h00EF00 && a <= 24'h00EFFF) return e[0] ? 7'h40 : e[1] ? 7'h01 : 7'h02;
        if (a >= 24'h00EE00 && a <= 24'h00EEFF) return e[1] ? 7'h20 : e[0] ? 7'h01 : 7'h02;
        if (a >= 24'h00EC00 && a <= 24'h00ECFF) return e[4] ? 7'h10 : (e[0] | e[1]) ? 7'h01 : 7'h02;
        if (a >= 24'h00E000 && a <= 24'h00E7FF) return e[2] ? 7'h08 : 7'h02;
        if (a >= 24'h00C000 && a <= 24'h00DFFF) return e[3] ? 7'h04 : 7'h02;
        return 7'h02;
    endfunction

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        if (a == periph_enable_pkg::CFG_OFFSET && !lock) cfg = d[4:0];
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        rq.push_back(exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic acc(input logic [23:0] a, input int gap);
        aq.push_back(route_exp(a, eff()));
        i_access_master.send(a, gap);
    endtask

    // Every window edge, mixing back-to-back and spaced accesses.
    task automatic sweep();
        logic [15:0] r;
        foreach (addrs[k]) acc(addrs[k], (k % 3 == 2) ? 1 : 0);
        r = rand16();
        acc({10'h003, r[13:0]}, 2);
    endtask

    // Pin levels are sampled mid-cycle once every synchroniser has settled.
    task automatic chk_pins();
        logic [4:0] e;
        repeat (3) @(posedge clk);
        @(negedge clk);
        e = eff();
        chk("can1_pins_gpio", 16'(can1_pins_gpio), 16'(!e[0]));
        chk("can2_pins_gpio", 16'(can2_pins_gpio), 16'(!e[1]));
        chk("rtc_osc_stop", 16'(rtc_osc_stop),
            16'(powerdown_req & (!e[4] | oscillator_off_select)));
        @(posedge clk);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        global_xperiph_enable <= 1'b0;
        mode_a <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        cfg = 5'h05;
        lock = 1'b0;
        emu = 1'b0;
        started = 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Monitors and watchdog
    // ----------------------------------------------------------------
    // Delayed strobes mark the one cycle in which each answer may stand.
    always @(posedge clk) begin
        acc_d <= acc_valid;
        rd_d <= reg_rd;
    end

    // Outside its answer cycle every verdict and the read data must be zero.
    always @(negedge clk) begin
        if (started) begin
            chk("route_valid", 16'(route_valid), 16'(acc_d));
            chk("route", 16'(route_vec), 16'(acc_d ? aq.pop_front() : 7'h00));
            chk("reg_rdata", reg_rdata, rd_d ? rq.pop_front() : 16'h0000);
        end
    end

    // The run needs about a thousand cycles; twenty times that means a hang.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] d;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        powerdown_req = 1'b0;
        oscillator_off_select = 1'b0;
        do_reset();
        rd(periph_enable_pkg::CFG_OFFSET, 16'h0005);
        chk_pins();
        wr(16'hF026, 16'hFFFF);
        rd(16'hF026, 16'h0000);
        @(posedge clk);
        rd(periph_enable_pkg::CFG_OFFSET, 16'h0005);
        sweep();
        for (int i = 0; i < 32; i++) begin
            d = rand16();
            d[4:0] = i[4:0];
            wr(periph_enable_pkg::CFG_OFFSET, d);
            rd(periph_enable_pkg::CFG_OFFSET, {11'h000, d[4:0]});
            powerdown_req <= rng[20];
            oscillator_off_select <= rng[21];
            sweep();
            chk_pins();
        end
        wr(periph_enable_pkg::CFG_OFFSET, 16'h0000);
        mode_a <= 1'b1;
        repeat (4) @(posedge clk);
        emu = 1'b1;
        rd(periph_enable_pkg::CFG_OFFSET, 16'h001F);
        sweep();
        chk_pins();
        mode_a <= 1'b0;
        repeat (4) @(posedge clk);
        emu = 1'b0;
        rd(periph_enable_pkg::CFG_OFFSET, 16'h0000);
        // Enables are programmed first, since the global enable freezes them.
        wr(periph_enable_pkg::CFG_OFFSET, 16'h000A);
        rd(periph_enable_pkg::CFG_OFFSET, 16'h000A);
        global_xperiph_enable <= 1'b1;
        lock = 1'b1;
        wr(periph_enable_pkg::CFG_OFFSET, 16'h0015);
        rd(periph_enable_pkg::CFG_OFFSET, 16'h000A);
        global_xperiph_enable <= 1'b0;
        wr(periph_enable_pkg::CFG_OFFSET, 16'h001F);
        rd(periph_enable_pkg::CFG_OFFSET, 16'h000A);
        sweep();
        do_reset();
        rd(periph_enable_pkg::CFG_OFFSET, 16'h0005);
        wr(periph_enable_pkg::CFG_OFFSET, 16'h001F);
        rd(periph_enable_pkg::CFG_OFFSET, 16'h001F);
        sweep();
        chk_pins();
        repeat (3) @(posedge clk);
        chk("queues", 16'(aq.size() + rq.size()), 16'h0000);
        complete_run();
    end
endmodule // tb_onchip_peripheral_enable_decoder
